// ===== design/qas_serial_port.sv
// serial port, straps and control pins of a four-channel converter
//
// The register addresses and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "qas_cfg.svh"

// What this block does
// - reset pulse realigns sampling of all channels
// - reset pulse returns interface to initial state
// - address straps inserted into every output word
// - mode strap low master, high slave
// - words sent only while chain enable high
// - chain done high after four-word transfer
// - receive frame sync direction follows mode
// - serial clock direction follows mode strap
// - ready falls when new word available
// - ready returns high after four words sent
// - ready high one cycle during word load
// - control data accepted inside a transmit frame begun while idle, or by apb write except in a cycle where a frame commits
// - aux input captured as flag in word
// - two outputs follow control register bits
// - result update no faster than 2.2 kHz
// - five binary cutoff settings scale update rate
module qas_serial_port
  import qas_pkg::*;
#(
  parameter int UPDATE_CYC = `QAS_UPDATE_CYC
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic [`QAS_NUM_CH*`QAS_RES_BITS-1:0] filt_result,
  input wire logic [`QAS_ID_BITS-1:0] device_id_straps,
  input wire logic mode_strap,
  input wire logic aux_flag_in,
  input wire logic chain_enable_in,
  output logic chain_done_out,
  output logic word_ready_n,
  output logic [1:0] front_end_ctrl_outs,
  input wire logic sclk_i,
  output logic sclk_o,
  output logic sclk_oe_n,
  input wire logic rx_frame_sync_n_i,
  output logic rx_frame_sync_n_o,
  output logic rx_frame_sync_n_oe_n,
  input wire logic serial_data_pin_i,
  output logic serial_data_pin_o,
  output logic serial_data_pin_oe_n,
  input wire logic tx_frame_sync_n
);

  // ----------------------------------------
  // functions
  // ----------------------------------------
  function automatic logic [2:0] clamp_cut(input logic [2:0] c);
    clamp_cut = (c > `QAS_CUT_MAX) ? `QAS_CUT_MAX : c;
  endfunction

  function automatic logic [`QAS_WORD_BITS-1:0] build_word(
    input logic [`QAS_ID_BITS-1:0] id,
    input logic [`QAS_CH_BITS-1:0] ch,
    input logic aux,
    input logic [`QAS_RES_BITS-1:0] res
  );
    build_word = '0;
    build_word[`QAS_ID_LSB +: `QAS_ID_BITS] = id;
    build_word[`QAS_CH_LSB +: `QAS_CH_BITS] = ch;
    build_word[`QAS_AUX_BIT] = aux;
    build_word[`QAS_RES_BITS-1:0] = res;
  endfunction

  // ----------------------------------------
  // pin synchronisers and straps
  // ----------------------------------------
  localparam int SYNC_W = 10;
  logic [SYNC_W-1:0] sync_s;
  logic [`QAS_ID_BITS-1:0] id_s;
  logic mode_s, aux_s, chain_s, sclk_s, rfs_n_s, serial_data_pin_s, tfs_n_s;

  qas_sync #(.W(SYNC_W)) u_sync (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .d({device_id_straps, mode_strap, aux_flag_in, chain_enable_in, sclk_i,
        rx_frame_sync_n_i, serial_data_pin_i, tx_frame_sync_n}),
    .q(sync_s)
  );

  assign {id_s, mode_s, aux_s, chain_s, sclk_s, rfs_n_s, serial_data_pin_s, tfs_n_s} = sync_s;

  logic [1:0] strap_cnt_q;
  logic [`QAS_ID_BITS-1:0] id_q;
  logic slave_q;

  // straps caught for a few cycles after release, once the synchroniser has filled
  always_ff @(posedge clk) begin
    if (reset) begin
      strap_cnt_q <= `QAS_STRAP_CAPTURE;
      id_q <= '0;
      slave_q <= 1'b0;
    end else if (ce && strap_cnt_q != 2'h0) begin
      strap_cnt_q <= strap_cnt_q - 2'h1;
      id_q <= id_s;
      slave_q <= mode_s;
    end
  end

  // ----------------------------------------
  // serial clock: generated in master mode, sampled in slave mode
  // ----------------------------------------
  localparam int HALF_CYC = `QAS_SCLK_HALF_CYC;
  qas_state_type st_q;
  logic [7:0] div_q;
  logic msclk_q, sclk_p_q, tfs_p_q;
  logic sclk_lvl, sclk_rise, sclk_fall, run_sclk, frame_ok, shift_ok;

  assign run_sclk = !slave_q && ((st_q == QAS_ST_SHIFT && chain_s) || (st_q == QAS_ST_CFG));

  always_ff @(posedge clk) begin
    if (reset) begin
      div_q <= 8'h00;
      msclk_q <= 1'b0;
    end else if (ce) begin
      if (!run_sclk) begin
        div_q <= 8'h00;
        msclk_q <= 1'b0;
      end else if (div_q == 8'(HALF_CYC - 1)) begin
        div_q <= 8'h00;
        msclk_q <= !msclk_q;
      end else begin
        div_q <= div_q + 8'h01;
      end
    end
  end

  assign sclk_lvl = slave_q ? sclk_s : msclk_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      sclk_p_q <= 1'b0;
      tfs_p_q <= 1'b1;
    end else if (ce) begin
      sclk_p_q <= sclk_lvl;
      tfs_p_q <= tfs_n_s;
    end
  end

  assign sclk_rise = sclk_lvl && !sclk_p_q;
  assign sclk_fall = !sclk_lvl && sclk_p_q;
  assign frame_ok = slave_q ? !rfs_n_s : 1'b1;
  assign shift_ok = frame_ok && chain_s;

  // ----------------------------------------
  // result update timer
  // ----------------------------------------
  logic [`QAS_CTRL_BITS-1:0] ctrl_q;
  logic [23:0] upd_cnt_q, upd_period;
  logic upd_tick;

  // halving the cutoff doubles the update period
  assign upd_period = 24'(UPDATE_CYC) << ctrl_q[`QAS_CTRL_CUT_LSB +: 3];
  assign upd_tick = (upd_cnt_q == upd_period - 24'h1);

  // restarted by reset so chips pulsed together stay aligned
  always_ff @(posedge clk) begin
    if (reset) begin
      upd_cnt_q <= 24'h0;
    end else if (ce) begin
      upd_cnt_q <= (upd_tick || upd_cnt_q >= upd_period) ? 24'h0 : upd_cnt_q + 24'h1;
    end
  end

  // ----------------------------------------
  // output word sequencer
  // ----------------------------------------
  logic [`QAS_RES_BITS-1:0] res_q [`QAS_NUM_CH];
  logic aux_q, pending_q, serial_data_pin_q;
  logic [`QAS_CH_BITS-1:0] widx_q;
  logic [4:0] bit_q;
  logic [`QAS_WORD_BITS-1:0] sh_q;
  logic [4:0] done_cnt_q;
  logic [`QAS_IRQ_BITS-1:0] ev;

  always_ff @(posedge clk) begin
    if (reset) begin
      st_q <= QAS_ST_IDLE;
      pending_q <= 1'b0;
      aux_q <= 1'b0;
      widx_q <= '0;
      bit_q <= 5'h00;
      sh_q <= '0;
      serial_data_pin_q <= 1'b0;
      for (int i = 0; i < `QAS_NUM_CH; i++) begin
        res_q[i] <= '0;
      end
    end else if (ce) begin
      // results only latched while idle so a word in flight never tears
      if (upd_tick && st_q == QAS_ST_IDLE) begin
        for (int i = 0; i < `QAS_NUM_CH; i++) begin
          res_q[i] <= filt_result[i*`QAS_RES_BITS +: `QAS_RES_BITS];
        end
        aux_q <= aux_s;
        pending_q <= 1'b1;
      end
      unique case (st_q)
        QAS_ST_IDLE: begin
          if (!tfs_n_s) begin
            st_q <= QAS_ST_CFG;
          end else if (pending_q && chain_s && !upd_tick) begin
            st_q <= QAS_ST_LOAD;
            pending_q <= 1'b0;
            widx_q <= '0;
          end
        end
        QAS_ST_LOAD: begin
          sh_q <= build_word(id_q, widx_q, aux_q, res_q[widx_q]);
          bit_q <= 5'h00;
          st_q <= QAS_ST_SHIFT;
        end
        QAS_ST_SHIFT: begin
          // bit changes on serial clock rise, host samples on fall
          if (sclk_rise && shift_ok) begin
            serial_data_pin_q <= sh_q[`QAS_WORD_BITS-1];
            sh_q <= {sh_q[`QAS_WORD_BITS-2:0], 1'b0};
          end
          if (sclk_fall && shift_ok) begin
            bit_q <= bit_q + 5'h01;
            if (bit_q == `QAS_LAST_BIT) begin
              if (widx_q == `QAS_LAST_CH) begin
                st_q <= QAS_ST_DONE;
              end else begin
                widx_q <= widx_q + 2'h1;
                st_q <= QAS_ST_LOAD;
              end
            end
          end
        end
        QAS_ST_DONE: begin
          st_q <= QAS_ST_IDLE;
        end
        QAS_ST_CFG: begin
          if (tfs_n_s) begin
            st_q <= QAS_ST_IDLE;
          end
        end
      endcase
    end
  end

  // chain done pulse: one short burst at the end of the fourth word
  always_ff @(posedge clk) begin
    if (reset) begin
      done_cnt_q <= 5'h00;
    end else if (ce) begin
      if (st_q == QAS_ST_DONE) begin
        done_cnt_q <= 5'(`QAS_CHAIN_DONE_CYC);
      end else if (done_cnt_q != 5'h00) begin
        done_cnt_q <= done_cnt_q - 5'h01;
      end
    end
  end

  assign chain_done_out = (done_cnt_q != 5'h00);
  assign word_ready_n = (st_q != QAS_ST_SHIFT);

  // ----------------------------------------
  // pin drivers
  // ----------------------------------------
  assign sclk_o = msclk_q;
  assign sclk_oe_n = slave_q;
  assign rx_frame_sync_n_o = (st_q != QAS_ST_SHIFT);
  assign rx_frame_sync_n_oe_n = slave_q;
  assign serial_data_pin_o = serial_data_pin_q;
  assign serial_data_pin_oe_n = !(st_q == QAS_ST_SHIFT && frame_ok);

  // ----------------------------------------
  // control register: serial frame and apb
  // ----------------------------------------
  logic [`QAS_CTRL_BITS-1:0] csh_q;
  logic [2:0] ccnt_q;
  logic ctrl_commit, apb_wr, apb_rd;
  logic [`QAS_IRQ_BITS-1:0] irq_stat_q, irq_mask_q;

  assign ctrl_commit = tfs_n_s && !tfs_p_q && st_q == QAS_ST_CFG && ccnt_q == 3'(`QAS_CTRL_BITS);
  assign apb_wr = psel && penable && pwrite;
  assign apb_rd = psel && !penable && !pwrite;

  always_ff @(posedge clk) begin
    if (reset) begin
      csh_q <= '0;
      ccnt_q <= 3'h0;
    end else if (ce) begin
      if (st_q != QAS_ST_CFG || tfs_n_s) begin
        ccnt_q <= 3'h0;
      end else if (sclk_fall) begin
        csh_q <= {csh_q[`QAS_CTRL_BITS-2:0], serial_data_pin_s};
        if (ccnt_q != 3'(`QAS_CTRL_BITS)) begin
          ccnt_q <= ccnt_q + 3'h1;
        end
      end
    end
  end

  // a short frame is dropped whole; an overlong one commits its last five bits
  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_q <= `QAS_CTRL_RST;
    end else if (ce) begin
      if (ctrl_commit) begin
        ctrl_q <= {clamp_cut(csh_q[`QAS_CTRL_CUT_LSB +: 3]), csh_q[1:0]};
      end else if (apb_wr && paddr == `QAS_OFF_CTRL) begin
        ctrl_q <= {clamp_cut(pwdata[`QAS_CTRL_CUT_LSB +: 3]), pwdata[1:0]};
      end
    end
  end

  assign front_end_ctrl_outs = ctrl_q[`QAS_CTRL_FE_LSB +: 2];

  // ----------------------------------------
  // interrupts and apb slave
  // ----------------------------------------
  always_comb begin
    ev = '0;
    ev[`QAS_IRQ_NEW] = upd_tick && st_q == QAS_ST_IDLE;
    ev[`QAS_IRQ_DONE] = st_q == QAS_ST_DONE;
    ev[`QAS_IRQ_CTRL] = ctrl_commit;
    ev[`QAS_IRQ_OVR] = upd_tick && (st_q != QAS_ST_IDLE || pending_q);
  end

  // set beats a simultaneous clear
  always_ff @(posedge clk) begin
    if (reset) begin
      irq_stat_q <= `QAS_IRQ_RST;
      irq_mask_q <= `QAS_IRQ_RST;
    end else if (ce) begin
      if (apb_wr && paddr == `QAS_OFF_IRQ_STAT) begin
        irq_stat_q <= (irq_stat_q & ~pwdata[`QAS_IRQ_BITS-1:0]) | ev;
      end else begin
        irq_stat_q <= irq_stat_q | ev;
      end
      if (apb_wr && paddr == `QAS_OFF_IRQ_MASK) begin
        irq_mask_q <= pwdata[`QAS_IRQ_BITS-1:0];
      end
    end
  end

  assign irq = |(irq_stat_q & irq_mask_q);

  // read data formed in the setup cycle, valid through the access cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      prdata <= 32'h0000_0000;
    end else if (ce && apb_rd) begin
      unique case (paddr)
        `QAS_OFF_CTRL: prdata <= {27'h0, ctrl_q};
        `QAS_OFF_STATUS: prdata <= {19'h0, chain_s, pending_q, widx_q, st_q, slave_q, id_q};
        `QAS_OFF_IRQ_STAT: prdata <= {28'h0, irq_stat_q};
        `QAS_OFF_IRQ_MASK: prdata <= {28'h0, irq_mask_q};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  assign pready = 1'b1;
  assign pslverr = psel && penable && !(paddr == `QAS_OFF_CTRL || paddr == `QAS_OFF_STATUS ||
                   paddr == `QAS_OFF_IRQ_STAT || paddr == `QAS_OFF_IRQ_MASK);

endmodule

`default_nettype wire

// ===== design/qas_cfg.svh
// constants for the quad converter serial port: offsets, fields, resets, timing
`ifndef QAS_CFG_SVH
`define QAS_CFG_SVH

// ----------------------------------------
// word and channel geometry
// ----------------------------------------
`define QAS_NUM_CH 4
`define QAS_CH_BITS 2
`define QAS_WORD_BITS 32
`define QAS_RES_BITS 22
`define QAS_ID_BITS 3
`define QAS_ID_LSB 29
`define QAS_CH_LSB 27
`define QAS_AUX_BIT 26
`define QAS_LAST_BIT 5'h1F
`define QAS_LAST_CH 2'h3

// ----------------------------------------
// timing
// ----------------------------------------
`define QAS_CLK_MHZ 100
`define QAS_MAX_UPDATE_HZ 2200
`define QAS_UPDATE_CYC ((`QAS_CLK_MHZ * 1000000 + `QAS_MAX_UPDATE_HZ - 1) / `QAS_MAX_UPDATE_HZ)
`define QAS_SCLK_MIN_PERIOD_NS 125
`define QAS_SCLK_PERIOD_CYC ((`QAS_SCLK_MIN_PERIOD_NS * `QAS_CLK_MHZ + 999) / 1000)
`define QAS_SCLK_HALF_CYC ((`QAS_SCLK_PERIOD_CYC + 1) / 2)
`define QAS_CHAIN_DONE_NS 250
`define QAS_CHAIN_DONE_CYC ((`QAS_CHAIN_DONE_NS * `QAS_CLK_MHZ) / 1000)
`define QAS_STRAP_CAPTURE 2'h3

// ----------------------------------------
// register map
// ----------------------------------------
`define QAS_OFF_CTRL 8'h00
`define QAS_OFF_STATUS 8'h04
`define QAS_OFF_IRQ_STAT 8'h08
`define QAS_OFF_IRQ_MASK 8'h0C

// control: [1:0] front-end outputs, [4:2] filter cutoff code
`define QAS_CTRL_BITS 5
`define QAS_CTRL_FE_LSB 0
`define QAS_CTRL_CUT_LSB 2
`define QAS_CTRL_RST 5'h00
`define QAS_CUT_MAX 3'h4

// interrupt bits
`define QAS_IRQ_BITS 4
`define QAS_IRQ_NEW 0
`define QAS_IRQ_DONE 1
`define QAS_IRQ_CTRL 2
`define QAS_IRQ_OVR 3
`define QAS_IRQ_RST 4'h0

`endif

// ===== design/qas_pkg.sv
// types shared by the quad converter serial port
package qas_pkg;

  typedef enum logic [4:0] {
    QAS_ST_IDLE  = 5'b00001,
    QAS_ST_LOAD  = 5'b00010,
    QAS_ST_SHIFT = 5'b00100,
    QAS_ST_DONE  = 5'b01000,
    QAS_ST_CFG   = 5'b10000
  } qas_state_type;

endpackage

// ===== design/qas_sync.sv
// two-flop synchroniser bank for pins from outside the clock domain
`timescale 1ns/1ps
`default_nettype none

module qas_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_q;

  // first stage feeds only the second
  always_ff @(posedge clk) begin
    if (reset) begin
      meta_q <= '0;
      q <= '0;
    end else if (ce) begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule

`default_nettype wire

// ===== dv/qas_host_model.sv
// host serial port model: word capture and control frames
`timescale 1ns/1ps
`default_nettype none
module qas_host_model (
  input wire logic sclk_w,
  input wire logic data_w,
  input wire logic rfs_w,
  input wire logic word_ready_n,
  output logic host_sclk,
  output logic host_data,
  output logic host_rfs,
  output logic tfs_n
);
  logic [31:0] sh;
  int nb;
  logic [31:0] words[$];
  initial begin
    host_sclk = 1'b0;
    host_data = 1'b0;
    host_rfs = 1'b1;
    tfs_n = 1'b1;
    nb = 0;
  end
  // sample on falling clock, never while a word loads
  always @(negedge sclk_w) begin
    if (!rfs_w && !word_ready_n) begin
      sh = {sh[30:0], data_w};
      nb++;
      if (nb == 32) begin
        words.push_back(sh);
        nb = 0;
      end
    end
  end
  // msb first; clock stands still outside the frame
  // data moves well after the fall: the port syncs clock and data alike
  task automatic send_ctrl(input logic [7:0] bits, input int n);
    tfs_n = 1'b0;
    #160;
    for (int i = n - 1; i >= 0; i--) begin
      #40 host_data = bits[i];
      #40 host_sclk = 1'b1;
      #80 host_sclk = 1'b0;
    end
    #160 tfs_n = 1'b1;
    host_data = ~host_data;
  endtask
endmodule
`default_nettype wire

// ===== dv/qas_serial_port_properties.sv
// concurrent checks on the serial port pins
`timescale 1ns/1ps
`default_nettype none
module qas_serial_port_props (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic mode_strap,
  input wire logic chain_enable_in,
  input wire logic chain_done_out,
  input wire logic word_ready_n,
  input wire logic [1:0] front_end_ctrl_outs,
  input wire logic sclk_o,
  input wire logic sclk_oe_n,
  input wire logic rx_frame_sync_n_oe_n,
  input wire logic serial_data_pin_oe_n,
  input wire logic tx_frame_sync_n
);
  logic [7:0] hi_cnt_q;
  logic [7:0] tfs_age_q;
  logic wr_q;
  always_ff @(posedge clk) begin
    if (reset || !chain_done_out) begin
      hi_cnt_q <= 8'h00;
    end else begin
      hi_cnt_q <= hi_cnt_q + 8'h01;
    end
  end
  // frame commit lands a few cycles after the frame closes
  always_ff @(posedge clk) begin
    if (reset || !tx_frame_sync_n) begin
      tfs_age_q <= 8'h00;
    end else if (tfs_age_q != 8'hFF) begin
      tfs_age_q <= tfs_age_q + 8'h01;
    end
  end
  always_ff @(posedge clk) begin
    wr_q <= psel && penable && pwrite;
  end
  default clocking dc @(posedge clk); endclocking
  default disable iff (reset);
  sequence chain_low_s;
    (!sclk_oe_n && !chain_enable_in) [*4];
  endsequence
  sequence word_end_s;
    !word_ready_n ##1 word_ready_n;
  endsequence
  property fe_write_p;
    logic [1:0] v;
    (psel && penable && pwrite && paddr == 8'h00, v = pwdata[1:0]) |=> front_end_ctrl_outs == v;
  endproperty
  word_load_a: assert property (word_end_s |=> !word_ready_n || chain_done_out)
    else $error("ready stayed high without transfer end");
  chain_pulse_a: assert property (!$past(reset) && $fell(chain_done_out) |-> hi_cnt_q == 8'h19)
    else $error("chain done pulse length wrong");
  sclk_stop_a: assert property (chain_low_s |=> $stable(sclk_o))
    else $error("serial clock ran with chain enable low");
  slave_dir_a: assert property (mode_strap [*8] |-> sclk_oe_n && rx_frame_sync_n_oe_n)
    else $error("slave mode drives clock or frame");
  master_dir_a: assert property ((!mode_strap) [*8] |-> !sclk_oe_n && !rx_frame_sync_n_oe_n)
    else $error("master mode not driving clock or frame");
  reset_exit_a: assert property ($fell(reset) |-> word_ready_n && !chain_done_out && serial_data_pin_oe_n
    && front_end_ctrl_outs == 2'h0)
    else $error("interface not in initial state after reset");
  fe_write_a: assert property (fe_write_p)
    else $error("front end outputs ignore control write");
  ctrl_gate_a: assert property ($changed(front_end_ctrl_outs) |-> wr_q || tfs_age_q < 8'h10)
    else $error("control changed outside write or frame");
endmodule
bind qas_serial_port qas_serial_port_props i_qas_serial_port_props (.clk, .reset, .psel, .penable, .pwrite,
  .paddr, .pwdata, .mode_strap, .chain_enable_in, .chain_done_out, .word_ready_n, .front_end_ctrl_outs,
  .sclk_o, .sclk_oe_n, .rx_frame_sync_n_oe_n, .serial_data_pin_oe_n, .tx_frame_sync_n);
`default_nettype wire

// ===== dv/qas_serial_port_tb.sv
// self-checking bench for the quad converter serial port
`timescale 1ns/1ps
`default_nettype none
`include "qas_cfg.svh"
module qas_serial_port_tb;
  localparam int UPD = 200;
  localparam logic [87:0] RES = {22'h1DEAD4, 22'h31C0D3, 22'h2BEEF2, 22'h0FACE1};
  logic clk, reset, ce, psel, penable, pwrite, pready, pslverr, irq, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0] ids;
  logic [1:0] fe;
  logic mode_strap, aux, cen, cdone, rdy_n, sclk_o, sclk_oe_n, rfs_o, rfs_oe_n, sd_o, sd_oe_n;
  logic sclk_w, rfs_w, sd_w, host_sclk, host_data, host_rfs, tfs_n;
  int miscompares, n_compared, cycles, n;
  assign sclk_w = sclk_oe_n ? host_sclk : sclk_o;
  assign rfs_w = rfs_oe_n ? host_rfs : rfs_o;
  assign sd_w = sd_oe_n ? host_data : sd_o;
  qas_serial_port #(.UPDATE_CYC(UPD)) i_qas_serial_port (.clk, .reset, .ce, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .irq, .filt_result(RES), .device_id_straps(ids), .mode_strap,
    .aux_flag_in(aux), .chain_enable_in(cen), .chain_done_out(cdone), .word_ready_n(rdy_n),
    .front_end_ctrl_outs(fe), .sclk_i(sclk_w), .sclk_o, .sclk_oe_n, .rx_frame_sync_n_i(rfs_w),
    .rx_frame_sync_n_o(rfs_o), .rx_frame_sync_n_oe_n(rfs_oe_n), .serial_data_pin_i(sd_w),
    .serial_data_pin_o(sd_o), .serial_data_pin_oe_n(sd_oe_n), .tx_frame_sync_n(tfs_n));
  qas_host_model i_qas_host_model (.sclk_w, .data_w(sd_w), .rfs_w, .word_ready_n(rdy_n), .host_sclk,
    .host_data, .host_rfs, .tfs_n);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 12000) begin
      miscompares++;
      give_verdict();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge clk);
  endtask
  // straps change only under reset
  task automatic rst(input logic m, input logic [2:0] id);
    @(posedge clk);
    reset <= 1'b1;
    mode_strap <= m;
    ids <= id;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    repeat (8) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    reset = 1'b1;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    ids = 3'h5;
    mode_strap = 1'b1;
    aux = 1'b1;
    cen = 1'b0;
    miscompares = 0;
    n_compared = 0;
    cycles = 0;
    rst(1'b1, 3'h5);
    chk(32'({sclk_oe_n, rfs_oe_n, rdy_n}), 32'h7, "slave pins");
    apb(1'b0, `QAS_OFF_STATUS, 32'h0);
    chk(32'(rd[3:0]), 32'hD, "straps");
    apb(1'b0, 8'h10, 32'h0);
    chk({err, rd[30:0]}, 32'h80000000, "unmapped");
    apb(1'b1, `QAS_OFF_CTRL, 32'h1D);
    chk(32'(fe), 32'h1, "bus ctrl");
    apb(1'b0, `QAS_OFF_CTRL, 32'h0);
    chk(rd, 32'h11, "cutoff clamp");
    i_qas_host_model.send_ctrl(8'h02, 5);
    repeat (20) @(negedge clk);
    chk(32'(fe), 32'h2, "frame ctrl");
    i_qas_host_model.send_ctrl(8'h01, 4);
    repeat (20) @(negedge clk);
    chk(32'(fe), 32'h2, "short frame");
    apb(1'b0, `QAS_OFF_IRQ_STAT, 32'h0);
    chk(32'(rd[2]), 32'h1, "frame irq");
    $display("test slave done");
    @(posedge clk);
    cen <= 1'b1;
    i_qas_host_model.words.delete();
    rst(1'b0, 3'h6);
    chk(32'({sclk_oe_n, rfs_oe_n}), 32'h0, "master pins");
    n = 8;
    while (rdy_n !== 1'b0) begin
      @(negedge clk);
      n++;
    end
    chk(32'(n > UPD - 20 && n < UPD + 20), 32'h1, "first word time");
    while (i_qas_host_model.words.size() < 4) @(negedge clk);
    @(posedge clk);
    cen <= 1'b0;
    n = 0;
    while (cdone !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    chk(32'({cdone, rdy_n}), 32'h3, "chain done");
    for (int i = 0; i < 4; i++) begin
      chk(i_qas_host_model.words[i], {3'h6, 2'(i), 1'b1, 4'h0, RES[22*i +: 22]}, "word");
    end
    repeat (30) @(negedge clk);
    apb(1'b0, `QAS_OFF_IRQ_STAT, 32'h0);
    chk(32'({rd[1], irq}), 32'h2, "done irq masked");
    apb(1'b1, `QAS_OFF_IRQ_MASK, 32'h2);
    repeat (2) @(negedge clk);
    chk(32'(irq), 32'h1, "irq raised");
    apb(1'b1, `QAS_OFF_IRQ_STAT, 32'h2);
    repeat (2) @(negedge clk);
    chk(32'(irq), 32'h0, "irq cleared");
    $display("test master done");
    repeat (800) @(negedge clk);
    chk(32'({i_qas_host_model.words.size(), rdy_n}), 32'h9, "chain held low");
    $display("test chain hold done");
    give_verdict();
  end
endmodule
`default_nettype wire
